// file: common/pfpc_map.svh
// Purpose: Register offsets, field positions, reset values and counts for pin control
// Assumes: Word-aligned byte addresses on a 5-bit Avalon address
// Notes: Definitions only
`ifndef PFPC_MAP_SVH
`define PFPC_MAP_SVH

// Widths of the pin groups
`define PFPC_PORTA_W 6
`define PFPC_PORTB_W 8
`define PFPC_KEY_W 8

// Register byte offsets
`define PFPC_OFS_SYSOPT 5'h00
`define PFPC_OFS_PULLA 5'h04
`define PFPC_OFS_PULLB 5'h08
`define PFPC_OFS_KBEN 5'h0C
`define PFPC_OFS_KBEDGE 5'h10
`define PFPC_OFS_DBGFRC 5'h14
`define PFPC_OFS_STATUS 5'h18
`define PFPC_OFS_CLKCFG 5'h1C

// System options field positions
`define PFPC_SO_RSTPIN 0
`define PFPC_SO_DBGPIN 1
`define PFPC_SO_IRQPIN 2
`define PFPC_SO_IRQPULLDIS 3
`define PFPC_SO_TWOWIRE 4

// Debug force reset field position
`define PFPC_DF_FORCE 0

// Pin positions on port A
`define PFPC_PIN_RESET 5
`define PFPC_PIN_MODE 4

// Reset values
`define PFPC_RST_DBGPIN 1'b1
`define PFPC_RST_CLKDIV 2'h1
`define PFPC_OSC_FREQ_MHZ 8'h10

// Internal reset stretch in bus cycles
`define PFPC_RST_HOLD_CYC 8'h10

`endif

// file: common/pfpc_pkg.sv
// Purpose: Types shared by the pin control block
// Assumes: Nothing beyond the map header
// Notes: Constants live in pfpc_map.svh
package pfpc_pkg;
  typedef enum logic [1:0] {RS_HOLD, RS_RUN} pfpc_rst_state_e;
  typedef enum logic [1:0] {CAUSE_POR, CAUSE_PIN, CAUSE_FORCE} pfpc_cause_e;
  typedef enum logic [1:0] {SHR_GPIO, SHR_IRQ, SHR_RESET} pfpc_share_e;
endpackage

// file: common/pfpc_pin_if.sv
// Purpose: Carries pin configuration to the pad controller and its results back
// Assumes: Single clock domain
// Notes: None
`timescale 1ns/1ps
`include "pfpc_map.svh"
interface pfpc_pin_if;
  logic rstPinEn;
  logic irqPinEn;
  logic irqPullDis;
  logic dbgPinEn;
  logic [`PFPC_PORTA_W-1:0] pullA;
  logic [`PFPC_PORTB_W-1:0] pullB;
  logic [`PFPC_KEY_W-1:0] kbEn;
  logic [`PFPC_KEY_W-1:0] kbEdge;
  logic [`PFPC_PORTA_W-1:0] outEnA;
  logic [`PFPC_PORTB_W-1:0] outEnB;
  logic [`PFPC_PORTA_W-1:0] pullEnA;
  logic [`PFPC_PORTA_W-1:0] pullDnA;
  logic [`PFPC_PORTB_W-1:0] pullEnB;
  logic [`PFPC_PORTB_W-1:0] pullDnB;
  pfpc_pkg::pfpc_share_e shareFunc;

  modport ctrl (
    output rstPinEn, irqPinEn, irqPullDis, dbgPinEn, pullA, pullB, kbEn, kbEdge,
    output outEnA, outEnB,
    input pullEnA, pullDnA, pullEnB, pullDnB, shareFunc
  );
  modport pad (
    input rstPinEn, irqPinEn, irqPullDis, dbgPinEn, pullA, pullB, kbEn, kbEdge,
    input outEnA, outEnB,
    output pullEnA, pullDnA, pullEnB, pullDnB, shareFunc
  );
endinterface

// file: rtl/pfpc_pad_ctrl.sv
// Purpose: Resolves pull device enable and direction per pin, and the shared pin function
// Assumes: Keyboard inputs 0-3 sit on port A 0-3, inputs 4-7 on port B 0-3
// Notes: Results are registered so the top can drive them straight out
`timescale 1ns/1ps
`include "pfpc_map.svh"
module pfpc_pad_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration in, pad settings out
  pfpc_pin_if.pad pins
);
  logic [`PFPC_PORTA_W-1:0] nxtEnA;
  logic [`PFPC_PORTA_W-1:0] nxtDnA;
  logic [`PFPC_PORTB_W-1:0] nxtEnB;
  logic [`PFPC_PORTB_W-1:0] nxtDnB;
  pfpc_pkg::pfpc_share_e nxtFunc;
  logic [`PFPC_PORTA_W-1:0] enA_ff;
  logic [`PFPC_PORTA_W-1:0] dnA_ff;
  logic [`PFPC_PORTB_W-1:0] enB_ff;
  logic [`PFPC_PORTB_W-1:0] dnB_ff;
  pfpc_pkg::pfpc_share_e func_ff;

  // Pull state of a plain input pin: {enable, pulldown}
  function automatic logic [1:0] pullOf(input logic userEn, input logic outEn,
                                        input logic kbEn, input logic kbEdge);
    logic en;
    en = userEn & ~outEn;
    pullOf = {en, en & kbEn & kbEdge};
  endfunction

  // Per-pin resolution, the dedicated functions override the user bits
  always_comb
  begin
    nxtEnA = '0;
    nxtDnA = '0;
    nxtEnB = '0;
    nxtDnB = '0;
    for (int i = 0; i < `PFPC_PORTA_W; i++)
    begin
      if (i < 4)
        {nxtEnA[i], nxtDnA[i]} = pullOf(pins.pullA[i], pins.outEnA[i], pins.kbEn[i],
                                        pins.kbEdge[i]);
      else
        {nxtEnA[i], nxtDnA[i]} = pullOf(pins.pullA[i], pins.outEnA[i], 1'b0, 1'b0);
    end
    for (int j = 0; j < `PFPC_PORTB_W; j++)
    begin
      {nxtEnB[j], nxtDnB[j]} = pullOf(pins.pullB[j], pins.outEnB[j], 1'b0, 1'b0);
    end
    // Keyboard inputs 4-7 sit on port B bits 0-3; separate loop keeps indices in range
    for (int k = 0; k < 4; k++)
    begin
      {nxtEnB[k], nxtDnB[k]} = pullOf(pins.pullB[k], pins.outEnB[k], pins.kbEn[k+4],
                                      pins.kbEdge[k+4]);
    end
    // Debug pin owns port A bit four with a forced pullup
    if (pins.dbgPinEn)
    begin
      nxtEnA[`PFPC_PIN_MODE] = 1'b1;
      nxtDnA[`PFPC_PIN_MODE] = 1'b0;
    end
    // Reset has highest priority on the shared pin, then the interrupt function
    nxtFunc = pfpc_pkg::SHR_GPIO;
    if (pins.rstPinEn)
    begin
      nxtFunc = pfpc_pkg::SHR_RESET;
      nxtEnA[`PFPC_PIN_RESET] = 1'b1;
      nxtDnA[`PFPC_PIN_RESET] = 1'b0;
    end
    else if (pins.irqPinEn)
    begin
      nxtFunc = pfpc_pkg::SHR_IRQ;
      nxtEnA[`PFPC_PIN_RESET] = ~pins.irqPullDis;
      nxtDnA[`PFPC_PIN_RESET] = 1'b0;
    end
  end

  // Register the pad settings
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      enA_ff <= '0;
      dnA_ff <= '0;
      enB_ff <= '0;
      dnB_ff <= '0;
      func_ff <= pfpc_pkg::SHR_GPIO;
    end
    else
    begin
      enA_ff <= nxtEnA;
      dnA_ff <= nxtDnA;
      enB_ff <= nxtEnB;
      dnB_ff <= nxtDnB;
      func_ff <= nxtFunc;
    end
  end

  assign pins.pullEnA = enA_ff;
  assign pins.pullDnA = dnA_ff;
  assign pins.pullEnB = enB_ff;
  assign pins.pullDnB = dnB_ff;
  assign pins.shareFunc = func_ff;
endmodule

// file: rtl/pfpc_top.sv
// Purpose: Pin function and pull device control with reset and debug mode entry
// Assumes: rst is the power-on reset; all registers run on the bus clock clk_sys
// Notes: Overview of operation follows
// Overview of operation
// - After power-on the shared port A bit five pin is a plain input.
// - Setting reset_pin_enable turns that pin into the active-low reset input.
// - Once set, reset_pin_enable stays set until the next power-on reset.
// - With the reset function on, a low on the pin resets the device.
// - With reset_pin_enable at 1 the pin pullup is on automatically.
// - With interrupt_pin_enable at 1 and reset_pin_enable at 0 the pullup follows interrupt_pullup_disable.
// - With debug_pin_enable at 1 port A bit four has its pullup on.
// - two_wire_pin_select moves the two-wire pins; default is port A bits two/three.
// - A keyboard pin with pull enabled gets a pulldown when its edge bit is set.
// - Every input pin has a software-selectable pullup.
// - A reset from the pin always restarts in user mode, never debug halt.
// - Debug halt follows a low mode pin at power-on or at a forced debug reset.
// - All registers are clocked by the bus clock.
// - Out of reset the clock source is 16 MHz with a bus divider giving 8 MHz.
// - debug_pin_enable is set by every reset and cleared by software.
`timescale 1ns/1ps
`include "pfpc_map.svh"
module pfpc_top (
  // Clock and power-on reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins and port direction from parallel I/O
  input wire logic [`PFPC_PORTA_W-1:0] portAPin,
  input wire logic [`PFPC_PORTA_W-1:0] portAOutEn,
  input wire logic [`PFPC_PORTB_W-1:0] portBOutEn,
  // System controls
  output logic sysReset,
  output logic debugHalt,
  output logic [1:0] shareFunc,
  output logic twoWireOnB,
  output logic [1:0] busClkDiv,
  // Pad settings
  output logic [`PFPC_PORTA_W-1:0] pullEnA,
  output logic [`PFPC_PORTA_W-1:0] pullDnA,
  output logic [`PFPC_PORTB_W-1:0] pullEnB,
  output logic [`PFPC_PORTB_W-1:0] pullDnB
);
  pfpc_pin_if pinBus ();

  // Pin synchroniser
  logic [`PFPC_PORTA_W-1:0] syncA1_ff;
  logic [`PFPC_PORTA_W-1:0] syncA2_ff;
  // Reset sequencer
  pfpc_pkg::pfpc_rst_state_e state_ff, nxtState;
  pfpc_pkg::pfpc_cause_e cause_ff, nxtCause;
  logic [7:0] cnt_ff, nxtCnt;
  logic halt_ff, nxtHalt;
  logic sysRst_ff, nxtSysRst;
  // Registers
  logic rstPinEn_ff, nxtRstPinEn;
  logic dbgPinEn_ff, nxtDbgPinEn;
  logic irqPinEn_ff, nxtIrqPinEn;
  logic interrupt_pullup_disable_ff, nxtIrqPdd;
  logic twoWire_ff, nxtTwoWire;
  logic [`PFPC_PORTA_W-1:0] pullA_ff, nxtPullA;
  logic [`PFPC_PORTB_W-1:0] pullB_ff, nxtPullB;
  logic [`PFPC_KEY_W-1:0] kbEn_ff, nxtKbEn;
  logic [`PFPC_KEY_W-1:0] kbEdge_ff, nxtKbEdge;
  logic [1:0] clkDiv_ff, nxtClkDiv;
  // Bus
  logic waitReq_ff, nxtWaitReq;
  logic [31:0] rdata_ff, nxtRdata;
  logic wrEn;
  logic forceReq;
  logic extReq;
  logic inRst;
  logic [31:0] rdMux;

  // Two flops before anything looks at the pins
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      syncA1_ff <= {`PFPC_PORTA_W{1'b1}};
      syncA2_ff <= {`PFPC_PORTA_W{1'b1}};
    end
    else
    begin
      syncA1_ff <= portAPin;
      syncA2_ff <= syncA1_ff;
    end
  end

  // Write lands only at the edge where waitrequest is seen low
  assign wrEn = avs_write & ~waitReq_ff;
  assign inRst = (state_ff == pfpc_pkg::RS_HOLD);
  assign extReq = rstPinEn_ff & ~syncA2_ff[`PFPC_PIN_RESET];
  assign forceReq = wrEn & (avs_address == `PFPC_OFS_DBGFRC) &
                    avs_writedata[`PFPC_DF_FORCE];

  // Reset sequencer: stretch every reset, then decide the run mode
  always_comb
  begin
    nxtState = state_ff;
    nxtCause = cause_ff;
    nxtCnt = cnt_ff;
    nxtHalt = halt_ff;
    unique case (state_ff)
      pfpc_pkg::RS_HOLD:
      begin
        if ((cause_ff == pfpc_pkg::CAUSE_PIN) && extReq)
          nxtCnt = 8'h00; // Held while the pin stays low
        else if (cnt_ff == `PFPC_RST_HOLD_CYC - 8'h01)
        begin
          nxtState = pfpc_pkg::RS_RUN;
          // Mode pin is sampled at release of a power-on or forced reset
          nxtHalt = (cause_ff != pfpc_pkg::CAUSE_PIN) &
                    ~syncA2_ff[`PFPC_PIN_MODE];
        end
        else
          nxtCnt = cnt_ff + 8'h01;
      end
      pfpc_pkg::RS_RUN:
      begin
        if (extReq)
        begin
          nxtState = pfpc_pkg::RS_HOLD;
          nxtCause = pfpc_pkg::CAUSE_PIN;
          nxtCnt = 8'h00;
          nxtHalt = 1'b0;
        end
        else if (forceReq)
        begin
          nxtState = pfpc_pkg::RS_HOLD;
          nxtCause = pfpc_pkg::CAUSE_FORCE;
          nxtCnt = 8'h00;
          nxtHalt = 1'b0;
        end
      end
    endcase
    nxtSysRst = (nxtState == pfpc_pkg::RS_HOLD);
  end

  // Sequencer state, power-on reset starts a full stretch
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_ff <= pfpc_pkg::RS_HOLD;
      cause_ff <= pfpc_pkg::CAUSE_POR;
      cnt_ff <= 8'h00;
      halt_ff <= 1'b0;
      sysRst_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxtState;
      cause_ff <= nxtCause;
      cnt_ff <= nxtCnt;
      halt_ff <= nxtHalt;
      sysRst_ff <= nxtSysRst;
    end
  end

  // Register file next values; internal reset forces defaults except the reset pin latch
  always_comb
  begin
    nxtRstPinEn = rstPinEn_ff;
    nxtDbgPinEn = dbgPinEn_ff;
    nxtIrqPinEn = irqPinEn_ff;
    nxtIrqPdd = interrupt_pullup_disable_ff;
    nxtTwoWire = twoWire_ff;
    nxtPullA = pullA_ff;
    nxtPullB = pullB_ff;
    nxtKbEn = kbEn_ff;
    nxtKbEdge = kbEdge_ff;
    nxtClkDiv = clkDiv_ff;
    if (inRst)
    begin
      nxtDbgPinEn = `PFPC_RST_DBGPIN;
      nxtIrqPinEn = 1'b0;
      nxtIrqPdd = 1'b0;
      nxtTwoWire = 1'b0;
      nxtPullA = '0;
      nxtPullB = '0;
      nxtKbEn = '0;
      nxtKbEdge = '0;
      nxtClkDiv = `PFPC_RST_CLKDIV;
    end
    else if (wrEn)
    begin
      unique case (avs_address)
        `PFPC_OFS_SYSOPT:
        begin
          // Write-once: software can set the reset function but never clear it
          nxtRstPinEn = rstPinEn_ff | avs_writedata[`PFPC_SO_RSTPIN];
          nxtDbgPinEn = avs_writedata[`PFPC_SO_DBGPIN];
          nxtIrqPinEn = avs_writedata[`PFPC_SO_IRQPIN];
          nxtIrqPdd = avs_writedata[`PFPC_SO_IRQPULLDIS];
          nxtTwoWire = avs_writedata[`PFPC_SO_TWOWIRE];
        end
        `PFPC_OFS_PULLA: nxtPullA = avs_writedata[`PFPC_PORTA_W-1:0];
        `PFPC_OFS_PULLB: nxtPullB = avs_writedata[`PFPC_PORTB_W-1:0];
        `PFPC_OFS_KBEN: nxtKbEn = avs_writedata[`PFPC_KEY_W-1:0];
        `PFPC_OFS_KBEDGE: nxtKbEdge = avs_writedata[`PFPC_KEY_W-1:0];
        `PFPC_OFS_CLKCFG: nxtClkDiv = avs_writedata[1:0];
        default: ; // Read-only and unmapped offsets ignore writes
      endcase
    end
  end

  // Register file, all on the bus clock
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rstPinEn_ff <= 1'b0;
      dbgPinEn_ff <= `PFPC_RST_DBGPIN;
      irqPinEn_ff <= 1'b0;
      interrupt_pullup_disable_ff <= 1'b0;
      twoWire_ff <= 1'b0;
      pullA_ff <= '0;
      pullB_ff <= '0;
      kbEn_ff <= '0;
      kbEdge_ff <= '0;
      clkDiv_ff <= `PFPC_RST_CLKDIV;
    end
    else
    begin
      rstPinEn_ff <= nxtRstPinEn;
      dbgPinEn_ff <= nxtDbgPinEn;
      irqPinEn_ff <= nxtIrqPinEn;
      interrupt_pullup_disable_ff <= nxtIrqPdd;
      twoWire_ff <= nxtTwoWire;
      pullA_ff <= nxtPullA;
      pullB_ff <= nxtPullB;
      kbEn_ff <= nxtKbEn;
      kbEdge_ff <= nxtKbEdge;
      clkDiv_ff <= nxtClkDiv;
    end
  end

  // Read decode; unmapped offsets and the force register read as zero
  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (avs_address)
      `PFPC_OFS_SYSOPT:
      begin
        rdMux[`PFPC_SO_RSTPIN] = rstPinEn_ff;
        rdMux[`PFPC_SO_DBGPIN] = dbgPinEn_ff;
        rdMux[`PFPC_SO_IRQPIN] = irqPinEn_ff;
        rdMux[`PFPC_SO_IRQPULLDIS] = interrupt_pullup_disable_ff;
        rdMux[`PFPC_SO_TWOWIRE] = twoWire_ff;
      end
      `PFPC_OFS_PULLA: rdMux[`PFPC_PORTA_W-1:0] = pullA_ff;
      `PFPC_OFS_PULLB: rdMux[`PFPC_PORTB_W-1:0] = pullB_ff;
      `PFPC_OFS_KBEN: rdMux[`PFPC_KEY_W-1:0] = kbEn_ff;
      `PFPC_OFS_KBEDGE: rdMux[`PFPC_KEY_W-1:0] = kbEdge_ff;
      `PFPC_OFS_STATUS:
      begin
        rdMux[0] = halt_ff;
        rdMux[2:1] = cause_ff;
        rdMux[8:3] = syncA2_ff;
        rdMux[10:9] = pinBus.shareFunc;
      end
      `PFPC_OFS_CLKCFG:
      begin
        rdMux[1:0] = clkDiv_ff;
        rdMux[15:8] = `PFPC_OSC_FREQ_MHZ;
      end
      default: ;
    endcase
  end

  // One wait cycle, then a single cycle with waitrequest low and data valid
  always_comb
  begin
    nxtWaitReq = 1'b1;
    nxtRdata = rdata_ff;
    if ((avs_read | avs_write) & waitReq_ff)
    begin
      nxtWaitReq = 1'b0;
      nxtRdata = avs_read ? rdMux : 32'h0000_0000;
    end
  end

  // Bus handshake registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      waitReq_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      waitReq_ff <= nxtWaitReq;
      rdata_ff <= nxtRdata;
    end
  end

  // Configuration to the pad controller
  assign pinBus.rstPinEn = rstPinEn_ff;
  assign pinBus.irqPinEn = irqPinEn_ff;
  assign pinBus.irqPullDis = interrupt_pullup_disable_ff;
  assign pinBus.dbgPinEn = dbgPinEn_ff;
  assign pinBus.pullA = pullA_ff;
  assign pinBus.pullB = pullB_ff;
  assign pinBus.kbEn = kbEn_ff;
  assign pinBus.kbEdge = kbEdge_ff;
  assign pinBus.outEnA = portAOutEn;
  assign pinBus.outEnB = portBOutEn;

  pfpc_pad_ctrl u_pad (
    .clk_sys(clk_sys),
    .rst(rst),
    .pins(pinBus.pad)
  );

  // Outputs straight from flops
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = waitReq_ff;
  assign sysReset = sysRst_ff;
  assign debugHalt = halt_ff;
  assign twoWireOnB = twoWire_ff;
  assign busClkDiv = clkDiv_ff;
  assign shareFunc = pinBus.shareFunc;
  assign pullEnA = pinBus.pullEnA;
  assign pullDnA = pinBus.pullDnA;
  assign pullEnB = pinBus.pullEnB;
  assign pullDnB = pinBus.pullDnB;
endmodule

// file: tb/pfpc_top_chk.sv
// Purpose: Port-level checks of pin function, pulls and reset entry
// Assumes: One bus clock, rst is the synchronous power-on reset
// Notes: Bound to pfpc_top from the bench top file
`timescale 1ns/1ps
`include "pfpc_map.svh"
module pfpc_top_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins and directions
  input wire logic [`PFPC_PORTA_W-1:0] portAPin,
  input wire logic [`PFPC_PORTA_W-1:0] portAOutEn,
  // System and pad outputs
  input wire logic sysReset,
  input wire logic debugHalt,
  input wire logic [1:0] shareFunc,
  input wire logic twoWireOnB,
  input wire logic [1:0] busClkDiv,
  input wire logic [`PFPC_PORTA_W-1:0] pullEnA,
  input wire logic [`PFPC_PORTA_W-1:0] pullDnA
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Shared pin state and its pull
  por_gpio_a: assert property ($fell(rst) |-> shareFunc == 2'h0)
    else $error("shared pin not gpio after power-on");
  rst_sticky_a: assert property ($past(shareFunc) == 2'h2 |-> shareFunc == 2'h2)
    else $error("reset function lost");
  rst_pull_a: assert property (shareFunc == 2'h2 && $past(shareFunc) == 2'h2
    |-> pullEnA[5] && !pullDnA[5]) else $error("reset pin pullup off");
  // Pin reset entry; pad is synced, so a few cycles of slack
  pin_reset_a: assert property ((shareFunc == 2'h2 && !portAPin[5])[*3]
    |-> ##[0:2] sysReset) else $error("low reset pin ignored");
  pin_user_a: assert property ($rose(shareFunc == 2'h2 && !portAPin[5])
    |-> ##[1:60] ($fell(sysReset) && !debugHalt)) else $error("pin reset left halt");
  por_halt_a: assert property ($fell(sysReset) && shareFunc != 2'h2 && !portAPin[4]
    && !$past(portAPin[4], 3) |-> debugHalt) else $error("mode pin low but no halt");
  // Defaults after any internal reset
  dbg_pull_a: assert property ($fell(sysReset) && !portAOutEn[4]
    |-> pullEnA[4] && !pullDnA[4]) else $error("debug pin pullup off after reset");
  clk_div_a: assert property ($fell(sysReset) |-> busClkDiv == `PFPC_RST_CLKDIV)
    else $error("divider not default after reset");
  // Port A bit 0 as an output never keeps its pullup
  outen_kill_a: assert property (portAOutEn[0] [*3] |-> !pullEnA[0])
    else $error("pullup on output pin");

  cover property ($rose(debugHalt));
  cover property ($rose(twoWireOnB));
  cover property ($fell(sysReset) && shareFunc == 2'h2);
endmodule

// file: tb/pfpc_pod_model.sv
// Purpose: External reset source and debug pod on port A
// Assumes: Both pins have device pullups, so released means high
// Notes: Bits 3..0 are plain inputs held at a fixed pattern
`timescale 1ns/1ps
`include "pfpc_map.svh"
module pfpc_pod_model (
  // Clock
  input wire logic clk_sys,
  // Commands from the bench
  input wire logic rstLow,
  input wire logic modeLow,
  // Levels seen at the device pins
  output logic [`PFPC_PORTA_W-1:0] pinLevel
);
  logic [`PFPC_PORTA_W-1:0] pinLevel_ff = 6'h3F;
  // Pins move just after an edge, like a real pod on the same board clock
  always_ff @(posedge clk_sys)
  begin
    pinLevel_ff[5] <= ~rstLow; // Driving low asks for reset
    pinLevel_ff[4] <= ~modeLow; // Held low across reset to ask for halt
    pinLevel_ff[3:0] <= 4'h5;
  end
  assign pinLevel = pinLevel_ff;
endmodule

// file: tb/tb_pfpc_top.sv
// Purpose: Self-checking bench for pin function and pull control
// Assumes: The slave answers every access; the master waits for waitrequest low
// Notes: Expectations follow the pad mapping of keyboard bits 0-3 to A, 4-7 to B
`timescale 1ns/1ps
`include "pfpc_map.svh"
module tb_pfpc_top;
  logic clkSys = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avsAddress = 5'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0000_0000;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic [5:0] portAPin;
  logic [5:0] portAOutEn = 6'h00;
  logic [7:0] portBOutEn = 8'h00;
  logic sysReset, debugHalt, twoWireOnB;
  logic [1:0] shareFunc, busClkDiv;
  logic [5:0] pullEnA, pullDnA;
  logic [7:0] pullEnB, pullDnB;
  logic rstLow = 1'b0;
  logic modeLow = 1'b0;
  logic [31:0] rd;
  int failCount = 0;
  int nCompared = 0;

  // 25 MHz bus clock
  always #20 clkSys = ~clkSys;

  pfpc_top i_dut (.clk_sys(clkSys), .rst(rst), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .portAPin(portAPin),
    .portAOutEn(portAOutEn), .portBOutEn(portBOutEn), .sysReset(sysReset),
    .debugHalt(debugHalt), .shareFunc(shareFunc), .twoWireOnB(twoWireOnB),
    .busClkDiv(busClkDiv), .pullEnA(pullEnA), .pullDnA(pullDnA), .pullEnB(pullEnB),
    .pullDnB(pullDnB));

  pfpc_pod_model i_pod (.clk_sys(clkSys), .rstLow(rstLow), .modeLow(modeLow),
    .pinLevel(portAPin));

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      failCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One access; held until waitrequest is seen low, then pads get time to follow
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clkSys);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    // No cycle count assumed; only the watchdog ends a wait that never completes
    do
    begin
      @(posedge clkSys);
    end
    while (avsWaitrequest !== 1'b0);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    repeat (3) @(posedge clkSys);
  endtask

  // Wait for the internal reset to reach a level, bounded
  task automatic waitSys(input logic lvl);
    int n;
    n = 0;
    while (sysReset !== lvl && n < 200)
    begin
      @(posedge clkSys);
      n++;
    end
    if (sysReset !== lvl)
      failCount++;
    repeat (2) @(posedge clkSys);
  endtask

  task automatic stopTest;
    if (failCount == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clkSys);
    failCount++;
    stopTest();
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clkSys);
    rst <= 1'b0;
    waitSys(1'b0);
    check("shareFunc", shareFunc, 2'h0);
    check("twoWireOnB", twoWireOnB, 1'b0);
    check("pullEnA", pullEnA, 6'h10);
    bus(1'b0, `PFPC_OFS_SYSOPT, 32'h0000_0000);
    check("sysopt", rd, 32'h0000_0002);
    bus(1'b0, `PFPC_OFS_CLKCFG, 32'h0000_0000);
    check("clkcfg", rd, 32'h0000_1001);
    check("busClkDiv", busClkDiv, `PFPC_RST_CLKDIV);
    // Divider moved away from default so the next internal reset must restore it
    bus(1'b1, `PFPC_OFS_CLKCFG, 32'h0000_0003);
    check("busClkDiv", busClkDiv, 2'h3);
    bus(1'b0, `PFPC_OFS_DBGFRC, 32'h0000_0000);
    check("dbgfrc", rd, 32'h0000_0000);
    // Pullups, with outputs on some pins
    portAOutEn <= 6'h01;
    portBOutEn <= 8'hF0;
    bus(1'b1, `PFPC_OFS_PULLA, 32'h0000_002F);
    bus(1'b1, `PFPC_OFS_PULLB, 32'h0000_00FF);
    check("pullEnA", pullEnA, 6'h3E);
    check("pullEnB", pullEnB, 8'h0F);
    // Keyboard edge turns enabled pulls into pulldowns
    bus(1'b1, `PFPC_OFS_KBEN, 32'h0000_0011);
    bus(1'b1, `PFPC_OFS_KBEDGE, 32'h0000_0011);
    check("pullDnA", pullDnA, 6'h00);
    check("pullDnB", pullDnB, 8'h01);
    portAOutEn <= 6'h00;
    repeat (3) @(posedge clkSys);
    check("pullDnA", pullDnA, 6'h01);
    // Two-wire relocation, then interrupt function with debug pin released
    bus(1'b1, `PFPC_OFS_SYSOPT, 32'h0000_0012);
    check("twoWireOnB", twoWireOnB, 1'b1);
    bus(1'b1, `PFPC_OFS_SYSOPT, 32'h0000_0004);
    check("shareFunc", shareFunc, 2'h1);
    check("pullEnA", pullEnA, 6'h2F);
    bus(1'b1, `PFPC_OFS_SYSOPT, 32'h0000_000C);
    check("pullEnA", pullEnA, 6'h0F);
    // Reset function wins over interrupt and cannot be cleared
    bus(1'b1, `PFPC_OFS_SYSOPT, 32'h0000_000D);
    check("shareFunc", shareFunc, 2'h2);
    check("pullEnA", pullEnA, 6'h2F);
    bus(1'b1, `PFPC_OFS_SYSOPT, 32'h0000_0000);
    bus(1'b0, `PFPC_OFS_SYSOPT, 32'h0000_0000);
    check("sysopt", rd, 32'h0000_0001);
    // Forced debug reset with the mode pin low
    modeLow <= 1'b1;
    bus(1'b1, `PFPC_OFS_DBGFRC, 32'h0000_0001);
    waitSys(1'b1);
    waitSys(1'b0);
    check("debugHalt", debugHalt, 1'b1);
    check("shareFunc", shareFunc, 2'h2);
    check("busClkDiv", busClkDiv, `PFPC_RST_CLKDIV);
    bus(1'b0, `PFPC_OFS_SYSOPT, 32'h0000_0000);
    check("sysopt", rd, 32'h0000_0003);
    // Status: halt, force cause, synced pins 10_0101, reset function
    bus(1'b0, `PFPC_OFS_STATUS, 32'h0000_0000);
    check("status", rd, 32'h0000_052D);
    // Pin reset from halt, mode pin still low: must come back in user mode
    rstLow <= 1'b1;
    waitSys(1'b1);
    repeat (3) @(posedge clkSys);
    rstLow <= 1'b0;
    waitSys(1'b0);
    check("debugHalt", debugHalt, 1'b0);
    // Power-on with mode pin low
    rst <= 1'b1;
    repeat (20) @(posedge clkSys);
    rst <= 1'b0;
    waitSys(1'b0);
    check("debugHalt", debugHalt, 1'b1);
    check("shareFunc", shareFunc, 2'h0);
    modeLow <= 1'b0;
    stopTest();
  end
endmodule

bind pfpc_top pfpc_top_chk i_chk (.clk_sys(clk_sys), .rst(rst), .portAPin(portAPin),
  .portAOutEn(portAOutEn), .sysReset(sysReset), .debugHalt(debugHalt),
  .shareFunc(shareFunc), .twoWireOnB(twoWireOnB), .busClkDiv(busClkDiv),
  .pullEnA(pullEnA), .pullDnA(pullDnA));
